/* File: rwr_checker.sv */
// Port checker for the reset and wake recovery block.
// Bound to rwr_reset_wake; sees its top ports only.
`timescale 1ns/1ns
`default_nettype none
module rwr_checker
   import rwr_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic sys_rst_in,
   // Watched ports
   input wire logic reset_pin_n_in,
   input wire logic stop_instr_in,
   input wire logic wdt_irq_mode_in,
   input wire logic irq_enable_in,
   input wire logic core_reset_out,
   input wire logic stop_mode_out,
   input wire logic wdt_irq_out,
   input wire logic [15:0] vector_hi_addr_out,
   input wire logic [15:0] vector_lo_addr_out,
   input wire logic [7:0] watchdog_control_register_out
);
   logic stop_seen_q;
   logic [6:0] low_cnt_q;
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   // Marks a recovery that began in Stop mode
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) stop_seen_q <= 1'b0;
      else if (!reset_pin_n_in) stop_seen_q <= 1'b0;
      else if (stop_mode_out) stop_seen_q <= 1'b1;
      else if ($fell(core_reset_out)) stop_seen_q <= 1'b0;
   end
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) low_cnt_q <= 7'h00;
      else if (reset_pin_n_in) low_cnt_q <= 7'h00;
      else if (low_cnt_q != 7'h7f) low_cnt_q <= low_cnt_q + 7'h01;
   end
   a_vector_hi_fixed: assert property (vector_hi_addr_out == 16'h0002)
      else $error("vector high address wrong");
   a_vector_lo_fixed: assert property (vector_lo_addr_out == 16'h0003)
      else $error("vector low address wrong");
   a_pin_holds_reset: assert property (!reset_pin_n_in [*5] |-> core_reset_out)
      else $error("core not held while pin low");
   a_pin_release_fast: assert property ($rose(reset_pin_n_in) && low_cnt_q == 7'h7f
      |-> ##[1:5] !core_reset_out) else $error("slow release after long pin low");
   a_pin_cause_flag: assert property (!reset_pin_n_in [*5] ##1 reset_pin_n_in
      |-> ##[1:80] watchdog_control_register_out[RWR_FLAG_PIN_POS])
      else $error("pin cause flag not set");
   a_stop_by_instr: assert property ($rose(stop_mode_out)
      |-> $past(stop_instr_in) || $past(stop_instr_in, 2)) else $error("stop without instr");
   a_sys_hold_len: assert property ($fell(core_reset_out) |-> $past(core_reset_out, 16))
      else $error("core reset hold too short");
   a_stop_cause_flag: assert property ($fell(core_reset_out) && stop_seen_q
      |-> ##[0:2] watchdog_control_register_out[RWR_FLAG_STOP_POS])
      else $error("stop cause flag not set");
   a_irq_after_rec: assert property (wdt_irq_out
      |-> wdt_irq_mode_in && irq_enable_in && !core_reset_out) else $error("bad irq");
endmodule : rwr_checker
bind rwr_reset_wake rwr_checker u_chk (.clock_in, .sys_rst_in, .reset_pin_n_in,
   .stop_instr_in, .wdt_irq_mode_in, .irq_enable_in, .core_reset_out, .stop_mode_out,
   .wdt_irq_out, .vector_hi_addr_out, .vector_lo_addr_out, .watchdog_control_register_out);
`default_nettype wire

/* File: rwr_far_model.sv */
// Far side: external reset driver and wake-capable pins.
// Commanded by tb_top just after clock edges.
`timescale 1ns/1ns
`default_nettype none
module rwr_far_model (
   // Clock
   input wire logic clock_in,
   // Commands
   input wire logic pull_low_in,
   input wire logic [7:0] flip_in,
   // Pins
   output logic reset_pin_n_out,
   output var logic [7:0] pins_out = 8'h00
);
   // Pin idles high through its pull-up
   assign reset_pin_n_out = !pull_low_in;
   always @(posedge clock_in) pins_out <= pins_out ^ flip_in;
endmodule : rwr_far_model
`default_nettype wire

/* File: rwr_pkg.sv */
// Package for the reset and wake recovery block.
// Assumes a 25 MHz system clock and a free-running watchdog oscillator.
package rwr_pkg;
   // Timing counts
   localparam int unsigned RWR_WDO_HOLD_CYCLES = 514;
   localparam int unsigned RWR_SYS_HOLD_CYCLES = 16;
   localparam int unsigned RWR_SHORT_RESET_CYCLES = 66;
   // Register access sub-address and reset values
   localparam logic [7:0] RWR_WAKE_SUBADDR = 8'h05;
   localparam logic [7:0] RWR_WAKE_EN_RESET = 8'h00;
   // Reset vector location
   localparam logic [15:0] RWR_VECTOR_HI_ADDR = 16'h0002;
   localparam logic [15:0] RWR_VECTOR_LO_ADDR = 16'h0003;
   // Cause flag positions in watchdog_control_register
   localparam int unsigned RWR_FLAG_STOP_POS = 0;
   localparam int unsigned RWR_FLAG_WDT_POS = 1;
   localparam int unsigned RWR_FLAG_PIN_POS = 2;
   typedef enum logic [2:0] {
      RWR_RUN = 3'b000,
      RWR_PIN_RST = 3'b001,
      RWR_STOP = 3'b010,
      RWR_WDO_HOLD = 3'b011,
      RWR_SYS_HOLD = 3'b100
   } rwr_state_t;
endpackage : rwr_pkg

/* File: rwr_reset_wake.sv */
// Reset sequencer and stop mode wake recovery.
// Assumes the core drives the port sub-address/control accesses below.
`timescale 1ns/1ns
`default_nettype none
module rwr_reset_wake
   import rwr_pkg::*;
#(
   parameter int unsigned PIN_COUNT = 8
) (
   // Clocks and reset
   input wire logic clock_in,
   input wire logic wdo_clk_in,
   input wire logic sys_rst_in,
   // External pins
   input wire logic reset_pin_n_in,
   input wire logic [PIN_COUNT-1:0] port_pins_in,
   // Core status
   input wire logic stop_instr_in,
   input wire logic wdt_timeout_in,
   input wire logic wdt_irq_mode_in,
   input wire logic irq_enable_in,
   input wire logic flags_clear_in,
   // Port register access
   input wire logic port_addr_we_in,
   input wire logic port_ctl_we_in,
   input wire logic [7:0] port_wdata_in,
   output logic [7:0] port_ctl_rdata_out,
   // Core control
   output logic core_reset_out,
   output logic stop_mode_out,
   output logic [15:0] vector_hi_addr_out,
   output logic [15:0] vector_lo_addr_out,
   output logic wdt_irq_out,
   output logic [7:0] watchdog_control_register_out
);
   initial begin
      if (PIN_COUNT != 8) begin
         $error("rwr_reset_wake: PIN_COUNT must be 8");
      end
   end

   rwr_state_t state_q;
   logic rst_s1_q, rst_s2_q;
   logic [7:0] sub_addr_q;
   logic [7:0] pin_wake_source_enable_q;
   logic [PIN_COUNT-1:0] pin_s1_q, pin_s2_q, pin_last_q;
   logic wdt_s1_q, wdt_s2_q;
   logic dog_s1_q, dog_s2_q;
   logic [PIN_COUNT-1:0] en_s1_q, en_s2_q;
   logic done_ok_q;
   logic rec_done;
   logic wake_any;
   logic wdo_done, done_s1_q, done_s2_q;
   logic [7:0] cnt_q;
   logic pin_reset_cause_flag_q;
   logic watchdog_timeout_cause_flag_q;
   logic stop_cause_flag_q;
   logic irq_pend_q;
   logic clr_wdo;

   // Reset pin and watchdog timeout synchronisers
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
         dog_s1_q <= 1'b0;
         dog_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= ~reset_pin_n_in;
         rst_s2_q <= rst_s1_q;
         dog_s1_q <= wdt_timeout_in;
         dog_s2_q <= dog_s1_q;
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sub_addr_q <= 8'h00;
         pin_wake_source_enable_q <= RWR_WAKE_EN_RESET;
      end else begin
         if (port_addr_we_in) begin
            sub_addr_q <= port_wdata_in;
         end
         if (port_ctl_we_in && sub_addr_q == RWR_WAKE_SUBADDR) begin
            pin_wake_source_enable_q <= port_wdata_in;
         end
      end
   end

   always_comb begin
      port_ctl_rdata_out = 8'h00;
      if (sub_addr_q == RWR_WAKE_SUBADDR) begin
         port_ctl_rdata_out = pin_wake_source_enable_q;
      end
   end

   always_ff @(posedge wdo_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_last_q <= '0;
         wdt_s1_q <= 1'b0;
         wdt_s2_q <= 1'b0;
         en_s1_q <= '0;
         en_s2_q <= '0;
      end else begin
         pin_s1_q <= port_pins_in;
         pin_s2_q <= pin_s1_q;
         pin_last_q <= pin_s2_q;
         wdt_s1_q <= wdt_timeout_in;
         wdt_s2_q <= wdt_s1_q;
         en_s1_q <= pin_wake_source_enable_q;
         en_s2_q <= en_s1_q;
      end
   end

   // enabled pin edge or watchdog wakes
   assign wake_any = |((pin_s2_q ^ pin_last_q) & en_s2_q) | wdt_s2_q;

   // Clear until the old completion is seen gone
   assign clr_wdo = (state_q != RWR_STOP) || !done_ok_q;

   rwr_wdo_counter #(
      .HOLD_CYCLES(RWR_WDO_HOLD_CYCLES)
   ) u_wdo (
      .wdo_clk_in(wdo_clk_in),
      .sys_rst_in(sys_rst_in),
      .stop_req_in(stop_mode_out),
      .wake_in(wake_any),
      .clr_in(clr_wdo),
      .done_out(wdo_done)
   );

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         done_s1_q <= 1'b0;
         done_s2_q <= 1'b0;
      end else begin
         done_s1_q <= wdo_done;
         done_s2_q <= done_s1_q;
      end
   end

   // Stale completion from a previous recovery is ignored
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         done_ok_q <= 1'b0;
      end else begin
         done_ok_q <= (state_q == RWR_STOP) && (done_ok_q || !done_s2_q);
      end
   end

   assign rec_done = (state_q == RWR_STOP) && done_s2_q && done_ok_q;

   // Sequencer; register file is never touched here
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_q <= RWR_RUN;
         cnt_q <= 8'h00;
      end else begin
         case (state_q)
            RWR_RUN: begin
               cnt_q <= 8'h00;
               if (rst_s2_q) begin
                  state_q <= RWR_PIN_RST;
               end else if (stop_instr_in) begin
                  state_q <= RWR_STOP;
               end
            end
            RWR_PIN_RST: begin
               if (cnt_q != 8'(RWR_SHORT_RESET_CYCLES)) begin
                  cnt_q <= cnt_q + 8'h01;
               // count RWR_SHORT_RESET_CYCLES first, then hold while low, exit on release
               end else if (!rst_s2_q) begin
                  state_q <= RWR_RUN;
               end
            end
            RWR_STOP: begin
               if (rst_s2_q) begin
                  state_q <= RWR_PIN_RST;
                  cnt_q <= 8'h00;
               end else if (rec_done) begin
                  state_q <= RWR_SYS_HOLD;
                  cnt_q <= 8'h00;
               end
            end
            RWR_SYS_HOLD: begin
               if (rst_s2_q) begin
                  state_q <= RWR_PIN_RST;
                  cnt_q <= 8'h00;
               end else if (cnt_q == 8'(RWR_SYS_HOLD_CYCLES - 1)) begin
                  state_q <= RWR_RUN;
               end else begin
                  cnt_q <= cnt_q + 8'h01;
               end
            end
            default: begin
               state_q <= RWR_RUN;
            end
         endcase
      end
   end

   // Cause flags; set wins over clear
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pin_reset_cause_flag_q <= 1'b0;
         watchdog_timeout_cause_flag_q <= 1'b0;
         stop_cause_flag_q <= 1'b0;
      end else begin
         if (flags_clear_in) begin
            pin_reset_cause_flag_q <= 1'b0;
            watchdog_timeout_cause_flag_q <= 1'b0;
            stop_cause_flag_q <= 1'b0;
         end
         if (state_q == RWR_PIN_RST && !rst_s2_q
             && cnt_q == 8'(RWR_SHORT_RESET_CYCLES)) begin
            pin_reset_cause_flag_q <= 1'b1;
         end
         if (rec_done) begin
            stop_cause_flag_q <= 1'b1;
            if (dog_s2_q) begin
               watchdog_timeout_cause_flag_q <= 1'b1;
            end
         end
      end
   end

   // interrupt only after recovery, irq mode
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         irq_pend_q <= 1'b0;
         wdt_irq_out <= 1'b0;
      end else begin
         wdt_irq_out <= 1'b0;
         if (rec_done && dog_s2_q && wdt_irq_mode_in && irq_enable_in) begin
            irq_pend_q <= 1'b1;
         end else if (state_q == RWR_PIN_RST) begin
            irq_pend_q <= 1'b0;
         end else if (state_q == RWR_SYS_HOLD
                      && cnt_q == 8'(RWR_SYS_HOLD_CYCLES - 1) && irq_pend_q) begin
            irq_pend_q <= 1'b0;
            wdt_irq_out <= 1'b1;
         end
      end
   end

   always_comb begin
      core_reset_out = (state_q == RWR_PIN_RST) || (state_q == RWR_SYS_HOLD)
                       || rec_done;
      stop_mode_out = (state_q == RWR_STOP);
   end

   assign vector_hi_addr_out = RWR_VECTOR_HI_ADDR;
   assign vector_lo_addr_out = RWR_VECTOR_LO_ADDR;

   assign watchdog_control_register_out = {5'h00, pin_reset_cause_flag_q,
                                           watchdog_timeout_cause_flag_q, stop_cause_flag_q};
endmodule : rwr_reset_wake
`default_nettype wire

/* File: rwr_wdo_counter.sv */
// Watchdog-oscillator side of stop recovery: wake latch and 514-cycle hold.
// Assumes wdo_clk_in runs during Stop mode while the system clock may not.
`timescale 1ns/1ns
`default_nettype none
module rwr_wdo_counter
   import rwr_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = RWR_WDO_HOLD_CYCLES
) (
   // Clock and reset
   input wire logic wdo_clk_in,
   input wire logic sys_rst_in,
   // Control
   input wire logic stop_req_in,
   input wire logic wake_in,
   input wire logic clr_in,
   // Status
   output logic done_out
);
   initial begin
      if (HOLD_CYCLES < 1 || HOLD_CYCLES > 65535) begin
         $error("rwr_wdo_counter: bad HOLD_CYCLES");
      end
   end
   logic [15:0] cnt_q;
   logic stop_s1_q, stop_s2_q;
   logic clr_s1_q, clr_s2_q;
   logic armed_q;
   always_ff @(posedge wdo_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         stop_s1_q <= 1'b0;
         stop_s2_q <= 1'b0;
         clr_s1_q <= 1'b0;
         clr_s2_q <= 1'b0;
      end else begin
         stop_s1_q <= stop_req_in;
         stop_s2_q <= stop_s1_q;
         clr_s1_q <= clr_in;
         clr_s2_q <= clr_s1_q;
      end
   end
   always_ff @(posedge wdo_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         armed_q <= 1'b0;
         cnt_q <= 16'h0000;
         done_out <= 1'b0;
      end else if (clr_s2_q) begin
         armed_q <= 1'b0;
         cnt_q <= 16'h0000;
         done_out <= 1'b0;
      end else if (!armed_q) begin
         if (stop_s2_q && wake_in) begin
            armed_q <= 1'b1;
         end
      end else if (cnt_q == 16'(HOLD_CYCLES - 1)) begin
         done_out <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
endmodule : rwr_wdo_counter
`default_nettype wire

/* File: tb_top.sv */
// Testbench for the reset and wake recovery block.
// Checker is bound to the design; far model drives the pins.
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import rwr_pkg::*;
;
   localparam int WDO_NS = 70;
   logic clock_in = 0, wdo_clk_in = 0, sys_rst_in = 1, stop_instr_in = 0;
   logic wdt_timeout_in = 0, wdt_irq_mode_in = 0, irq_enable_in = 0, flags_clear_in = 0;
   logic port_addr_we_in = 0, port_ctl_we_in = 0, pull_low = 0, reset_pin_n_in;
   logic core_reset_out, stop_mode_out, wdt_irq_out;
   logic [7:0] port_wdata_in = 0, flip = 0, port_pins_in, port_ctl_rdata_out;
   logic [7:0] watchdog_control_register_out, addr_q = 0, en_q = 0, mask;
   logic [15:0] vector_hi_addr_out, vector_lo_addr_out;
   logic [31:0] seed = 32'h50;
   int failures = 0, checks = 0, cycles = 0, irqs = 0, lat;
   rwr_reset_wake u_dut (.clock_in, .wdo_clk_in, .sys_rst_in, .reset_pin_n_in,
      .port_pins_in, .stop_instr_in, .wdt_timeout_in, .wdt_irq_mode_in, .irq_enable_in,
      .flags_clear_in, .port_addr_we_in, .port_ctl_we_in, .port_wdata_in,
      .port_ctl_rdata_out, .core_reset_out, .stop_mode_out, .vector_hi_addr_out,
      .vector_lo_addr_out, .wdt_irq_out, .watchdog_control_register_out);
   rwr_far_model u_far (.clock_in, .pull_low_in(pull_low), .flip_in(flip),
      .reset_pin_n_out(reset_pin_n_in), .pins_out(port_pins_in));
   initial forever #20 clock_in = ~clock_in;
   initial forever #(WDO_NS / 2) wdo_clk_in = ~wdo_clk_in;
   task automatic complete_run();
      if (failures == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   always @(posedge clock_in) begin
      cycles++;
      if (wdt_irq_out === 1'b1) irqs++;
      if (cycles == 20000) begin
         failures++;
         complete_run();
      end
   end
   task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s exp %h seen %h", name, exp, seen);
      end
   endtask : chk
   function automatic logic [31:0] xs(logic [31:0] v);
      logic [31:0] a;
      a = v ^ (v << 13);
      a = a ^ (a >> 17);
      return a ^ (a << 5);
   endfunction : xs
   function automatic logic [7:0] flags(logic s, logic w, logic p);
      flags = 8'h00;
      flags[RWR_FLAG_STOP_POS] = s;
      flags[RWR_FLAG_WDT_POS] = w;
      flags[RWR_FLAG_PIN_POS] = p;
   endfunction : flags
   task automatic step(int n);
      repeat (n) @(posedge clock_in);
   endtask : step
   // Address write when a is set, control write otherwise
   task automatic wr(logic a, logic [7:0] d);
      step(1);
      port_addr_we_in <= a;
      port_ctl_we_in <= !a;
      port_wdata_in <= d;
      step(1);
      port_addr_we_in <= 1'b0;
      port_ctl_we_in <= 1'b0;
      if (a) addr_q = d;
      else if (addr_q == RWR_WAKE_SUBADDR) en_q = d;
   endtask : wr
   task automatic pulse_stop_clr();
      step(1);
      flags_clear_in <= 1'b1;
      step(1);
      flags_clear_in <= 1'b0;
      stop_instr_in <= 1'b1;
      step(1);
      stop_instr_in <= 1'b0;
      step(3);
   endtask : pulse_stop_clr
   task automatic wait_run();
      for (lat = 0; lat < 3000 && (stop_mode_out !== 1'b0 || core_reset_out !== 1'b0); lat++)
         step(1);
   endtask : wait_run
   initial begin
      step(16);
      sys_rst_in <= 1'b0;
      step(2);
      chk("cause_flags", 16'(watchdog_control_register_out), 16'h0000);
      chk("vec_hi", vector_hi_addr_out, 16'h0002);
      chk("vec_lo", vector_lo_addr_out, 16'h0003);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         wr(1'b1, (i % 2 == 0) ? RWR_WAKE_SUBADDR : seed[15:8]);
         wr(1'b0, seed[7:0]);
         step(1);
         chk("wake_en", 16'(port_ctl_rdata_out),
            16'((addr_q == RWR_WAKE_SUBADDR) ? en_q : 8'h00));
      end
      pull_low <= 1'b1;
      step(5);
      pull_low <= 1'b0;
      step(4);
      chk("short_reset", 16'(core_reset_out), 16'h0001);
      wait_run();
      chk("pin_flag", 16'(watchdog_control_register_out), 16'(flags(0, 0, 1)));
      pull_low <= 1'b1;
      step(150);
      chk("held", 16'(core_reset_out), 16'h0001);
      pull_low <= 1'b0;
      step(5);
      chk("release", 16'(core_reset_out), 16'h0000);
      seed = xs(seed);
      mask = 8'h01 << seed[2:0];
      wr(1'b1, RWR_WAKE_SUBADDR);
      wr(1'b0, mask);
      pulse_stop_clr();
      chk("stop_entry", 16'(stop_mode_out), 16'h0001);
      flip <= ~mask;
      step(1);
      flip <= 8'h00;
      step(100);
      chk("masked_pins", 16'(stop_mode_out), 16'h0001);
      flip <= mask;
      step(1);
      flip <= 8'h00;
      wait_run();
      chk("hold_long", 16'(lat >= RWR_WDO_HOLD_CYCLES * WDO_NS / 40), 16'h0001);
      chk("pin_wake", 16'(watchdog_control_register_out), 16'(flags(1, 0, 0)));
      for (int m = 1; m >= 0; m--) begin
         wdt_irq_mode_in <= m[0];
         irq_enable_in <= 1'b1;
         pulse_stop_clr();
         wdt_timeout_in <= 1'b1;
         wait_run();
         wdt_timeout_in <= 1'b0;
         step(10);
         chk("dog_flags", 16'(watchdog_control_register_out), 16'(flags(1, 1, 0)));
         chk("irq_count", 16'(irqs), 16'h0001);
      end
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
